// ===== logic/icom_pkg.sv
/*
 input conditioning and output matrix constants.
 assumes a 250 MHz pclk and a 32-bit apb slave.
*/
package icom_pkg;
    // ------------------------------------------------------------------
    // register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_HW_CFG = 8'h00;
    localparam logic [7:0] OFF_HW_STATUS = 8'h04;
    localparam logic [7:0] OFF_DELAY_ONE = 8'h08;
    localparam logic [7:0] OFF_DELAY_TWO = 8'h0c;
    localparam logic [7:0] OFF_COUNT_ONE = 8'h10;
    localparam logic [7:0] OFF_COUNT_TWO = 8'h14;
    localparam logic [7:0] OFF_SOFT_IN = 8'h18;
    localparam logic [7:0] OFF_KEY_CFG = 8'h1c;
    localparam logic [7:0] OFF_RELEASE = 8'h20;
    localparam logic [7:0] OFF_AUTO_TIME = 8'h24;
    localparam logic [7:0] OFF_EVENTS = 8'h28;
    localparam logic [7:0] OFF_LATCH_SEL = 8'h2c;
    localparam logic [7:0] OFF_DEST_STATE = 8'h30;
    localparam logic [7:0] OFF_MATRIX = 8'h40;
    // ------------------------------------------------------------------
    // sizes
    // ------------------------------------------------------------------
    localparam int NUM_HW = 2;
    localparam int NUM_SOFT = 4;
    localparam int NUM_SRC = 32;
    localparam int NUM_DEST = 24;
    localparam int NUM_EXT_SRC = 20;
    // destination indices: trip 0..3, signal 4, soft outputs 5..10,
    // indicators 11..18, key indicators 19..20, recorder 21
    localparam int DEST_LED_LO = 11;
    localparam int DEST_LED_HI = 20;
    localparam int DEST_RECORDER = 21;
    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 250000000;
    localparam int STEP_MS = 10;
    localparam int STEP_CYCLES = CLK_HZ / 1000 * STEP_MS;
    localparam logic [12:0] DELAY_MAX_STEPS = 13'h1770;
    localparam logic [31:0] DEST_RESET = 32'h0;
    localparam logic [1:0] KEY_DEFAULT_SEL_ONE = 2'h0;
    localparam logic [1:0] KEY_DEFAULT_SEL_TWO = 2'h1;
endpackage

// ===== logic/icom_core.sv
/*
 input conditioning, soft inputs, front keys and output matrix.
 assumes raw pins async to pclk; external sources synchronous to pclk.
*/
// Function
// RULE_01: two hardware inputs, each with a readable status bit
// RULE_02: inversion per input selects rising or falling active edge
// RULE_03: one delay 0 to 60 s in 10 ms steps for both transitions
// RULE_04: sixteen bit active-edge counter per input, software writable
// RULE_05: indication option pulses pop-up at each active edge
// RULE_06: active-edge event only when its enable is on
// RULE_07: inactive-edge event only when its separate enable is on
// RULE_08: conditioned inputs exported as sources to other matrices
// RULE_09: four soft inputs writable from display, bus and tool
// RULE_10: six soft outputs are matrix destinations and exported sources
// RULE_11: front keys toggle soft input one and two, reconfigurable
// RULE_12: any source may connect to any destination
// RULE_13: eight general indicators A to H are destinations
// RULE_14: two key indicators and recorder trigger are destinations
// RULE_15: non-latched destination follows OR of its sources
// RULE_16: latched destination sets and holds until released
// RULE_17: auto release clears old latched indicators on new event
// RULE_18: indicator becomes old after release time since event ended
// RULE_19: common release clears all latches from input, panel or bus
// RULE_20: delay restarts on reversal, acts as stability filter
// RULE_21: counter wraps from maximum to zero
`timescale 1ns/1ps
module icom_core #(
    parameter int STEP_CYCLES = icom_pkg::STEP_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // raw pins and keys
    input wire logic hw_input_one,
    input wire logic hw_input_two,
    input wire logic front_key_one,
    input wire logic front_key_two,
    // other writers of soft inputs
    input wire logic [3:0] soft_set_panel,
    input wire logic [3:0] soft_clr_panel,
    input wire logic [3:0] soft_set_tool,
    input wire logic [3:0] soft_clr_tool,
    // release requests
    input wire logic release_panel,
    input wire logic release_comm,
    // internal sources
    input wire logic [19:0] ext_src,
    // conditioned and soft state out
    output logic [1:0] hw_state,
    output logic [3:0] soft_input,
    output logic [5:0] soft_output,
    // destinations
    output logic [3:0] trip_relay,
    output logic signal_relay,
    output logic [7:0] led,
    output logic [1:0] key_led,
    output logic disturbance_recorder_trigger,
    // event and key pulses
    output logic [1:0] popup_pulse,
    output logic [1:0] on_event,
    output logic [1:0] off_event,
    output logic [1:0] key_obj_cmd
);
    localparam int NS = icom_pkg::NUM_SRC;
    localparam int ND = icom_pkg::NUM_DEST;

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [1:0] cfg_invert;
    logic [1:0] cfg_popup;
    logic [1:0] cfg_on_ev;
    logic [1:0] cfg_off_ev;
    logic [1:0] cfg_rel_sel;
    logic cfg_rel_hw_en;
    logic cfg_auto;
    logic [12:0] delay_steps [2];
    logic [15:0] edge_count [2];
    logic [12:0] auto_steps;
    logic [3:0] key_cfg [2];
    logic [ND-1:0] latch_sel;
    logic [ND-1:0] matrix [NS];
    logic [ND-1:0] dest;
    logic [3:0] soft_in;
    logic [1:0] key_obj;
    logic [1:0] popup;
    logic [1:0] ev_on;
    logic [1:0] ev_off;
    logic [1:0] ev_on_sticky;
    logic [1:0] ev_off_sticky;

    function automatic logic [12:0] clamp_delay(input logic [31:0] v);
        clamp_delay = (v[12:0] > icom_pkg::DELAY_MAX_STEPS || |v[31:13]) ?
            icom_pkg::DELAY_MAX_STEPS : v[12:0];
    endfunction

    // ------------------------------------------------------------------
    // apb access
    // ------------------------------------------------------------------
    logic wr;
    logic rd;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;
    assign pready = 1'b1;
    always_comb begin
        pslverr = 1'b0;
        if (psel && penable && paddr > icom_pkg::OFF_MATRIX + 8'h7c) begin
            pslverr = 1'b1;
        end
        if (psel && penable && paddr[1:0] != 2'h0) begin
            pslverr = 1'b1;
        end
        if (psel && penable && paddr > icom_pkg::OFF_DEST_STATE
                && paddr < icom_pkg::OFF_MATRIX) begin
            pslverr = 1'b1;
        end
    end
    logic wr_ok;
    assign wr_ok = wr & ~pslverr & (&pstrb);

    // ------------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------------
    logic [3:0] sync_a;
    logic [3:0] sync_b;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else begin
            sync_a <= {front_key_two, front_key_one, hw_input_two, hw_input_one};
            sync_b <= sync_a;
        end
    end

    // ------------------------------------------------------------------
    // step tick
    // ------------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic tick;
    assign tick = (tick_cnt == 32'(STEP_CYCLES - 1));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 32'h0;
        end else if (tick) begin
            tick_cnt <= 32'h0;
        end else begin
            tick_cnt <= tick_cnt + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // hardware input conditioning
    // ------------------------------------------------------------------
    logic [1:0] level;
    logic [1:0] act_edge;
    logic [1:0] inact_edge;
    logic [12:0] stab_cnt [2];
    logic [1:0] pend;
    for (genvar i = 0; i < 2; i++) begin : g_hw
        logic raw;
        logic next_level;
        assign raw = sync_b[i];
        always_comb begin
            next_level = level[i];
            if (raw == level[i]) begin
                next_level = level[i];
            end else if (delay_steps[i] == 13'h0) begin
                next_level = raw; // RULE_03
            end else if (pend[i] && tick && stab_cnt[i] + 13'h1 >= delay_steps[i]) begin
                next_level = raw; // RULE_20
            end
        end
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                level[i] <= 1'b0;
                stab_cnt[i] <= 13'h0;
                pend[i] <= 1'b0;
            end else begin
                level[i] <= next_level; // RULE_01
                if (raw == level[i] || next_level != level[i]) begin
                    stab_cnt[i] <= 13'h0; // RULE_20
                    pend[i] <= 1'b0;
                end else if (!pend[i]) begin
                    pend[i] <= 1'b1;
                    stab_cnt[i] <= 13'h0;
                end else if (tick) begin
                    stab_cnt[i] <= stab_cnt[i] + 13'h1; // RULE_03
                end
            end
        end
        // active edge follows inversion setting
        assign act_edge[i] = cfg_invert[i] ? (level[i] & ~next_level)
                                           : (~level[i] & next_level); // RULE_02
        assign inact_edge[i] = (level[i] != next_level) & ~act_edge[i];
    end
    assign hw_state = level; // RULE_08

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            popup <= 2'h0;
            ev_on <= 2'h0;
            ev_off <= 2'h0;
        end else begin
            popup <= act_edge & cfg_popup; // RULE_05
            ev_on <= act_edge & cfg_on_ev; // RULE_06
            ev_off <= inact_edge & cfg_off_ev; // RULE_07
        end
    end
    assign popup_pulse = popup;
    assign on_event = ev_on;
    assign off_event = ev_off;

    // counters, edge wins over software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            edge_count[0] <= 16'h0;
            edge_count[1] <= 16'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (act_edge[i]) begin
                    edge_count[i] <= edge_count[i] + 16'h1; // RULE_21
                end else if (wr_ok && paddr == icom_pkg::OFF_COUNT_ONE + 8'(4 * i)) begin
                    edge_count[i] <= pwdata[15:0]; // RULE_04
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // front keys and soft inputs
    // ------------------------------------------------------------------
    logic [1:0] key_prev;
    logic [1:0] key_press;
    logic [3:0] toggle;
    assign key_press = sync_b[3:2] & ~key_prev;
    always_comb begin
        toggle = 4'h0;
        for (int k = 0; k < 2; k++) begin
            if (key_press[k] && !key_cfg[k][2]) begin
                toggle[key_cfg[k][1:0]] = 1'b1; // RULE_11
            end
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_prev <= 2'h0;
            key_obj <= 2'h0;
        end else begin
            key_prev <= sync_b[3:2];
            key_obj <= key_press & {key_cfg[1][2], key_cfg[0][2]}; // RULE_11
        end
    end
    assign key_obj_cmd = key_obj;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            soft_in <= 4'h0;
        end else begin
            soft_in <= ((((wr_ok && paddr == icom_pkg::OFF_SOFT_IN) ? pwdata[3:0] : soft_in)
                | soft_set_panel | soft_set_tool)
                & ~(soft_clr_panel | soft_clr_tool)) ^ toggle; // RULE_09
        end
    end
    assign soft_input = soft_in;

    // ------------------------------------------------------------------
    // output matrix
    // ------------------------------------------------------------------
    logic [NS-1:0] src;
    assign src = {soft_output, soft_in, level, ext_src}; // RULE_12
    logic [ND-1:0] drive;
    always_comb begin
        drive = '0;
        for (int s = 0; s < NS; s++) begin
            if (src[s]) begin
                drive = drive | matrix[s]; // RULE_12
            end
        end
    end

    // release sources
    logic release_all;
    assign release_all = release_panel | release_comm
        | (wr_ok && paddr == icom_pkg::OFF_RELEASE && pwdata[0])
        | (cfg_rel_hw_en & level[cfg_rel_sel[0]]); // RULE_19

    // auto release: indicator latches age once their drive ends
    logic [ND-1:0] drive_prev;
    logic [12:0] age [ND];
    logic [ND-1:0] old;
    logic new_event;
    logic [ND-1:0] led_mask;
    always_comb begin
        led_mask = '0;
        for (int d = icom_pkg::DEST_LED_LO; d <= icom_pkg::DEST_LED_HI; d++) begin
            led_mask[d] = 1'b1;
        end
    end
    assign new_event = |(drive & ~drive_prev & latch_sel & led_mask);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_prev <= '0;
            old <= '0;
            for (int d = 0; d < ND; d++) begin
                age[d] <= 13'h0;
            end
        end else begin
            drive_prev <= drive;
            for (int d = 0; d < ND; d++) begin
                if (drive[d] || !dest[d]) begin
                    age[d] <= 13'h0;
                    old[d] <= 1'b0;
                end else if (tick && !old[d]) begin
                    if (age[d] + 13'h1 >= auto_steps) begin
                        old[d] <= 1'b1; // RULE_18
                    end
                    age[d] <= age[d] + 13'h1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dest <= icom_pkg::DEST_RESET[ND-1:0];
        end else begin
            for (int d = 0; d < ND; d++) begin
                if (!latch_sel[d]) begin
                    dest[d] <= drive[d]; // RULE_15
                end else if (drive[d]) begin
                    dest[d] <= 1'b1; // RULE_16
                end else if (release_all) begin
                    dest[d] <= 1'b0; // RULE_19
                end else if (cfg_auto && led_mask[d] && old[d] && new_event) begin
                    dest[d] <= 1'b0; // RULE_17
                end
            end
        end
    end
    assign trip_relay = dest[3:0];
    assign signal_relay = dest[4];
    assign soft_output = dest[10:5]; // RULE_10
    assign led = dest[18:11]; // RULE_13
    assign key_led = dest[20:19]; // RULE_14
    assign disturbance_recorder_trigger = dest[icom_pkg::DEST_RECORDER]; // RULE_14

    // ------------------------------------------------------------------
    // configuration writes
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_invert <= 2'h0;
            cfg_popup <= 2'h0;
            cfg_on_ev <= 2'h0;
            cfg_off_ev <= 2'h0;
            cfg_rel_sel <= 2'h0;
            cfg_rel_hw_en <= 1'b0;
            cfg_auto <= 1'b0;
            delay_steps[0] <= 13'h0;
            delay_steps[1] <= 13'h0;
            auto_steps <= 13'h0;
            key_cfg[0] <= {2'h0, icom_pkg::KEY_DEFAULT_SEL_ONE};
            key_cfg[1] <= {2'h0, icom_pkg::KEY_DEFAULT_SEL_TWO};
            latch_sel <= '0;
            for (int s = 0; s < NS; s++) begin
                matrix[s] <= '0;
            end
        end else if (wr_ok) begin
            unique case (paddr)
                icom_pkg::OFF_HW_CFG: begin
                    cfg_invert <= pwdata[1:0];
                    cfg_popup <= pwdata[3:2];
                    cfg_on_ev <= pwdata[5:4];
                    cfg_off_ev <= pwdata[7:6];
                    cfg_rel_sel <= pwdata[9:8];
                    cfg_rel_hw_en <= pwdata[10];
                    cfg_auto <= pwdata[11];
                end
                icom_pkg::OFF_DELAY_ONE: delay_steps[0] <= clamp_delay(pwdata);
                icom_pkg::OFF_DELAY_TWO: delay_steps[1] <= clamp_delay(pwdata);
                icom_pkg::OFF_AUTO_TIME: auto_steps <= clamp_delay(pwdata);
                icom_pkg::OFF_KEY_CFG: begin
                    key_cfg[0] <= {1'b0, pwdata[2:0]};
                    key_cfg[1] <= {1'b0, pwdata[6:4]};
                end
                icom_pkg::OFF_LATCH_SEL: latch_sel <= pwdata[ND-1:0];
                default: begin
                    if (paddr >= icom_pkg::OFF_MATRIX) begin
                        matrix[paddr[6:2] ^ 5'h10] <= pwdata[ND-1:0];
                    end
                end
            endcase
        end
    end

    // sticky edge flags, set wins over read clear
    logic ev_rd;
    assign ev_rd = rd && paddr == icom_pkg::OFF_EVENTS;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_on_sticky <= 2'h0;
            ev_off_sticky <= 2'h0;
        end else begin
            ev_on_sticky <= (ev_rd ? 2'h0 : ev_on_sticky) | (act_edge & cfg_on_ev);
            ev_off_sticky <= (ev_rd ? 2'h0 : ev_off_sticky) | (inact_edge & cfg_off_ev);
        end
    end

    // ------------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------------
    always_comb begin
        prdata = 32'h0;
        unique case (paddr)
            icom_pkg::OFF_HW_CFG: prdata = {20'h0, cfg_auto, cfg_rel_hw_en, cfg_rel_sel,
                                            cfg_off_ev, cfg_on_ev, cfg_popup, cfg_invert};
            icom_pkg::OFF_HW_STATUS: prdata = {30'h0, level}; // RULE_01
            icom_pkg::OFF_DELAY_ONE: prdata = {19'h0, delay_steps[0]};
            icom_pkg::OFF_DELAY_TWO: prdata = {19'h0, delay_steps[1]};
            icom_pkg::OFF_COUNT_ONE: prdata = {16'h0, edge_count[0]};
            icom_pkg::OFF_COUNT_TWO: prdata = {16'h0, edge_count[1]};
            icom_pkg::OFF_SOFT_IN: prdata = {28'h0, soft_in};
            icom_pkg::OFF_KEY_CFG: prdata = {24'h0, key_cfg[1], key_cfg[0]};
            icom_pkg::OFF_AUTO_TIME: prdata = {19'h0, auto_steps};
            icom_pkg::OFF_EVENTS: prdata = {28'h0, ev_off_sticky, ev_on_sticky};
            icom_pkg::OFF_LATCH_SEL: prdata = {8'h0, latch_sel};
            icom_pkg::OFF_DEST_STATE: prdata = {8'h0, dest};
            default: begin
                if (paddr >= icom_pkg::OFF_MATRIX && paddr[1:0] == 2'h0) begin
                    prdata = {8'h0, matrix[paddr[6:2] ^ 5'h10]};
                end
            end
        endcase
    end
endmodule

// ===== tb/icom_field.sv
/*
 switchgear contacts and front keys seen by the device.
 assumes the bench sets the commanded levels just after pclk edges.
*/
`timescale 1ns/1ps
module icom_field (
    // commanded levels
    input wire logic [1:0] contact,
    input wire logic [1:0] press,
    // pins toward the device
    output logic hw_input_one,
    output logic hw_input_two,
    output logic front_key_one,
    output logic front_key_two
);
    // contacts and keys are plain levels, no bounce
    assign hw_input_one = contact[0];
    assign hw_input_two = contact[1];
    assign front_key_one = press[0];
    assign front_key_two = press[1];
endmodule

// ===== tb/icom_core_asserts.sv
/*
 port checker for icom_core.
 assumes it is bound to every icom_core instance.
*/
`timescale 1ns/1ps
module icom_core_asserts (
    // watched ports
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] hw_state,
    input wire logic [1:0] on_event,
    input wire logic [1:0] off_event,
    input wire logic [1:0] popup_pulse,
    input wire logic [3:0] soft_input,
    input wire logic [3:0] soft_set_panel,
    input wire logic [3:0] soft_clr_panel,
    input wire logic [3:0] soft_clr_tool
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence set_req;
        soft_set_panel[2] && !soft_clr_panel[2] && !soft_clr_tool[2];
    endsequence
    sequence clr_req;
        soft_clr_panel[2] || soft_clr_tool[2];
    endsequence
    ready_zero_wait_a: assert property (psel && penable |-> pready)
        else $error("pready low in access phase");
    err_in_access_a: assert property (pslverr |-> psel && penable)
        else $error("pslverr outside access phase");
    on_cause_a: assert property (on_event[0] |-> hw_state[0] != $past(hw_state[0]))
        else $error("on event without state change");
    off_cause_a: assert property (off_event[0] |-> hw_state[0] != $past(hw_state[0]))
        else $error("off event without state change");
    popup_cause_a: assert property (popup_pulse[0] |-> hw_state[0] != $past(hw_state[0]))
        else $error("popup without state change");
    edge_excl_a: assert property (!(on_event[0] && off_event[0]))
        else $error("on and off event together");
    soft_set_a: assert property (set_req |=> soft_input[2])
        else $error("soft input not set");
    soft_clr_a: assert property (clr_req |=> !soft_input[2])
        else $error("soft input not cleared");
endmodule
bind icom_core icom_core_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .pslverr(pslverr), .hw_state(hw_state),
    .on_event(on_event), .off_event(off_event), .popup_pulse(popup_pulse),
    .soft_input(soft_input), .soft_set_panel(soft_set_panel),
    .soft_clr_panel(soft_clr_panel), .soft_clr_tool(soft_clr_tool));

// ===== tb/tb_top.sv
/*
 self-checking bench for icom_core.
 assumes icom_field as the far side and STEP_CYCLES of 4.
*/
`timescale 1ns/1ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, last_err;
    logic [7:0] paddr, led;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] contact, press, hw_state;
    logic hw1, hw2, key1, key2, rel_p, rel_c, rec;
    logic [3:0] sset, sclr, soft_input, trip;
    logic [19:0] ext_src;
    logic [5:0] soft_output;
    int mismatches, checks, n;
    icom_field u_field (.contact(contact), .press(press), .hw_input_one(hw1),
        .hw_input_two(hw2), .front_key_one(key1), .front_key_two(key2));
    icom_core #(.STEP_CYCLES(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hw_input_one(hw1), .hw_input_two(hw2), .front_key_one(key1),
        .front_key_two(key2), .soft_set_panel(sset), .soft_clr_panel(4'h0),
        .soft_set_tool(4'h0), .soft_clr_tool(sclr), .release_panel(rel_p),
        .release_comm(rel_c), .ext_src(ext_src), .hw_state(hw_state),
        .soft_input(soft_input), .soft_output(soft_output), .trip_relay(trip),
        .signal_relay(), .led(led), .key_led(), .disturbance_recorder_trigger(rec),
        .popup_pulse(), .on_event(), .off_event(), .key_obj_cmd());
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task pin_to(input logic v);
        contact[0] <= v;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (hw_state[0] !== v && n < 200);
    endtask
    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task t_reset;
        apb(1'b0, icom_pkg::OFF_DEST_STATE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, icom_pkg::OFF_KEY_CFG, 32'h0);
        chk(rd, 32'h10);
        $display("test reset done");
    endtask
    task t_input;
        apb(1'b1, icom_pkg::OFF_DELAY_ONE, 32'h2);
        apb(1'b1, icom_pkg::OFF_HW_CFG, 32'h54);
        contact[0] <= 1'b1;
        repeat (3) @(posedge pclk);
        contact[0] <= 1'b0;
        repeat (20) @(posedge pclk);
        chk(hw_state, 32'h0);
        pin_to(1'b1);
        chk(n > 6, 32'h1);
        apb(1'b0, icom_pkg::OFF_COUNT_ONE, 32'h0);
        chk(rd, 32'h1);
        apb(1'b0, icom_pkg::OFF_EVENTS, 32'h0);
        chk(rd, 32'h1);
        pin_to(1'b0);
        apb(1'b0, icom_pkg::OFF_EVENTS, 32'h0);
        chk(rd, 32'h4);
        apb(1'b1, icom_pkg::OFF_COUNT_ONE, 32'hffff);
        pin_to(1'b1);
        apb(1'b0, icom_pkg::OFF_COUNT_ONE, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, icom_pkg::OFF_HW_STATUS, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, icom_pkg::OFF_HW_CFG, 32'h55);
        pin_to(1'b0);
        apb(1'b0, icom_pkg::OFF_COUNT_ONE, 32'h0);
        chk(rd, 32'h1);
        $display("test input done");
    endtask
    task t_matrix;
        apb(1'b1, icom_pkg::OFF_MATRIX, 32'h200821);
        apb(1'b1, icom_pkg::OFF_LATCH_SEL, 32'h800);
        ext_src[0] <= 1'b1;
        repeat (3) @(posedge pclk);
        chk({rec, soft_output[0], led[0], trip[0]}, 32'hf);
        ext_src[0] <= 1'b0;
        repeat (3) @(posedge pclk);
        chk({rec, soft_output[0], led[0], trip[0]}, 32'h2);
        apb(1'b1, icom_pkg::OFF_RELEASE, 32'h1);
        repeat (2) @(posedge pclk);
        chk(led[0], 32'h0);
        for (int i = 0; i < 2; i++) begin
            ext_src[0] <= 1'b1;
            @(posedge pclk);
            ext_src[0] <= 1'b0;
            repeat (3) @(posedge pclk);
            chk(led[0], 32'h1);
            rel_c <= (i == 0);
            rel_p <= (i == 1);
            repeat (2) @(posedge pclk);
            chk(led[0], 32'h0);
            rel_c <= 1'b0;
            rel_p <= 1'b0;
        end
        $display("test matrix done");
    endtask
    task t_soft;
        press[0] <= 1'b1;
        repeat (20) if (soft_input[0] !== 1'b1) @(posedge pclk);
        chk(soft_input, 32'h1);
        sset[2] <= 1'b1;
        @(posedge pclk);
        sset[2] <= 1'b0;
        @(posedge pclk);
        chk(soft_input, 32'h5);
        sclr[2] <= 1'b1;
        @(posedge pclk);
        sclr[2] <= 1'b0;
        @(posedge pclk);
        chk(soft_input, 32'h1);
        apb(1'b1, icom_pkg::OFF_SOFT_IN, 32'h9);
        @(posedge pclk);
        chk(soft_input, 32'h9);
        apb(1'b0, 8'h34, 32'h0);
        chk(last_err, 32'h1);
        $display("test soft done");
    endtask
    task give_verdict;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------------
    // clock, sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, rel_p, rel_c} = 6'h0;
        {paddr, pwdata, contact, press, sset, sclr, ext_src} = '0;
        mismatches = 0;
        checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_input;
        t_matrix;
        t_soft;
        give_verdict;
    end
    initial begin
        #80000;
        mismatches++;
        give_verdict;
    end
endmodule
